/* File: dsp_map.svh */
// Register offsets, reset values and timing figures of the protection supervisor
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH

// ==========================================================================
// Register byte offsets
`define DSP_OFS_CTRL 8'h00
`define DSP_OFS_STATUS 8'h04
`define DSP_OFS_MASK 8'h08
`define DSP_OFS_TRIP 8'h0c
`define DSP_OFS_TEXT 8'h40
`define DSP_OFS_SHOWN 8'h80

// ==========================================================================
// Field positions
`define DSP_CTRL_RIDE_BIT 0
`define DSP_CTRL_STALL_BIT 1
`define DSP_CTRL_PLOSS_LSB 2
`define DSP_CTRL_OVC_BIT 4
`define DSP_TRIP_ACTIVE_BIT 4
`define DSP_TRIP_RIDE_BIT 8
`define DSP_TRIP_CLEAR_BIT 31

// ==========================================================================
// Reset values
`define DSP_CTRL_RESET 5'h11
`define DSP_MASK_RESET 8'h00

// ==========================================================================
// Timing figures and clock rate
`define DSP_CLK_KHZ 125000
`define DSP_STALL_TIME_MS 5000
`define DSP_PLOSS_RUN_MS 500
`define DSP_PLOSS_DC_MS 50
`define DSP_PLOSS_FAST_MS 10
`define DSP_BLINK_HALF_MS 250

`endif

/* File: dsp_pkg.sv */
// Types shared by the protection supervisor
package dsp_pkg;

  // ========================================================================
  // Supervisor state, gray along run -> ride -> trip
  typedef enum logic [1:0] {
    DSP_RUN = 2'b00,
    DSP_RIDE = 2'b01,
    DSP_TRIP = 2'b11
  } dsp_state_t;

  // Trip codes reported to the drive
  typedef enum logic [3:0] {
    DSP_TC_NONE = 4'h0,
    DSP_TC_OVERVOLT = 4'h1,
    DSP_TC_MOTOR_LOST = 4'h2,
    DSP_TC_LOCKED_ROTOR = 4'h3,
    DSP_TC_EXT1 = 4'h4,
    DSP_TC_EXT2 = 4'h5,
    DSP_TC_EXT3 = 4'h6,
    DSP_TC_EXT4 = 4'h7
  } dsp_trip_t;

  // Phase-loss setting and start modes
  typedef enum logic [1:0] {
    DSP_PL_OFF = 2'h0,
    DSP_PL_TRIP = 2'h1,
    DSP_PL_START = 2'h2
  } dsp_ploss_t;

  typedef enum logic [1:0] {
    DSP_SM_NORMAL = 2'h0,
    DSP_SM_DC = 2'h1,
    DSP_SM_FAST = 2'h2
  } dsp_start_t;

  // Software settings
  typedef struct packed {
    logic ovc_en;
    dsp_ploss_t ploss_mode;
    logic stall_en;
    logic ride_en;
  } dsp_ctrl_t;

  // Sticky event bits, also the mask layout
  typedef struct packed {
    logic [3:0] ext;
    logic overvolt;
    logic motor_lost;
    logic stall;
    logic ride_start;
  } dsp_evt_t;

  // Measurement inputs from the drive
  typedef struct packed {
    logic mains_dip;
    logic standstill;
    logic torque_mode;
    logic torque_limit;
    logic speed_very_low;
    logic accelerating;
    logic decelerating;
    logic dc_link_high;
    logic chopper_fault;
    logic phase_missing;
    logic in_start;
    dsp_start_t start_mode;
    logic [3:0] ext_trip;
  } dsp_meas_t;

endpackage : dsp_pkg

/* File: dsp_supervisor.sv */
// Protection supervisor: ride-through, stall, phase loss, overvoltage, trip texts
`timescale 1ns/100ps
`default_nettype none
`include "dsp_map.svh"

// Behaviour
// - Dip with ride-through on slows motor to hold DC link level.
// - Ride-through setting 0 never slows motor on a dip.
// - Ride-through setting 1, default, ramps down until voltage returns.
// - Trip/limit LED blinks during ride-through.
// - Torque mode disables ride-through and overvoltage control.
// - Torque limit at low speed accelerating over 5 s: coast and fault.
// - Stall setting 0 off by default, 1 trips as locked rotor.
// - Phase loss held 500 ms in normal running trips and coasts.
// - Phase-loss time is 50 ms in DC start, 10 ms in fast start.
// - Phase-loss setting 0, the default, detects nothing.
// - Phase-loss setting 1 trips on lost motor, reporting motor lost.
// - Phase-loss setting 2 tests only during the start routine.
// - Overvoltage control limits deceleration while stopping.
// - Defective brake chopper or resistor trips as overvoltage.
// - Overvoltage control setting 0 off, 1 on, on by default.
// - Four editable 16-character trip texts, defaults Ext Trip 1 to 4.
module dsp_supervisor #(
  parameter int unsigned STALL_CYC = `DSP_STALL_TIME_MS * `DSP_CLK_KHZ,
  parameter int unsigned PLOSS_RUN_CYC = `DSP_PLOSS_RUN_MS * `DSP_CLK_KHZ,
  parameter int unsigned PLOSS_DC_CYC = `DSP_PLOSS_DC_MS * `DSP_CLK_KHZ,
  parameter int unsigned PLOSS_FAST_CYC = `DSP_PLOSS_FAST_MS * `DSP_CLK_KHZ,
  parameter int unsigned BLINK_CYC = `DSP_BLINK_HALF_MS * `DSP_CLK_KHZ
) (
  input wire logic clk, // 125 MHz system clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [3:0] avs_byteenable, // Write byte lanes
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall until answer is ready
  input wire dsp_pkg::dsp_meas_t meas, // Drive measurement state
  output logic speed_ramp_down, // Reduce speed to hold DC link
  output logic decel_limit, // Hold back deceleration rate
  output logic coast_stop, // Remove drive, motor coasts
  output logic [3:0] trip_code, // Latched trip code
  output logic led_trip_limit, // Trip/limit indicator
  output logic irq // Level interrupt
);

  // ========================================================================
  // Constant text defaults: "Ext Trip N" then spaces
  localparam logic [71:0] TEXT_STEM = 72'h45_78_74_20_54_72_69_70_20;
  localparam logic [7:0] ASCII_ONE = 8'h31;
  localparam logic [7:0] ASCII_SPACE = 8'h20;

  // ========================================================================
  // State
  dsp_pkg::dsp_state_t state;
  dsp_pkg::dsp_state_t next_state;
  dsp_pkg::dsp_trip_t trip;
  dsp_pkg::dsp_trip_t next_trip;
  dsp_pkg::dsp_ctrl_t ctrl;
  dsp_pkg::dsp_ctrl_t next_ctrl;
  dsp_pkg::dsp_evt_t status;
  dsp_pkg::dsp_evt_t next_status;
  dsp_pkg::dsp_evt_t mask;
  dsp_pkg::dsp_evt_t next_mask;
  logic [31:0] stall_cnt;
  logic [31:0] next_stall_cnt;
  logic [31:0] ploss_cnt;
  logic [31:0] next_ploss_cnt;
  logic [31:0] blink_cnt;
  logic [31:0] next_blink_cnt;
  logic blink;
  logic next_blink;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [7:0] text [0:63];
  logic [7:0] next_text [0:63];

  // Decode and detection terms
  logic access;
  logic wr_go;
  logic rd_go;
  logic ride_allowed;
  logic stall_cond;
  logic ploss_cond;
  logic [31:0] ploss_limit;
  logic stall_expired;
  logic ploss_expired;
  logic trip_clear;
  dsp_pkg::dsp_evt_t events;
  dsp_pkg::dsp_trip_t new_trip;
  logic [3:0] shown_idx;
  logic [5:0] word_sel;

  // ========================================================================
  // Avalon slave handshake: every access answers at the second edge
  always_comb begin
    access = avs_read | avs_write;
    next_ack = access & ~ack;
    avs_waitrequest = access & ~ack;
    wr_go = avs_write & ack;
    rd_go = avs_read & ~ack;
    word_sel = avs_address[7:2];
    trip_clear = wr_go && (avs_address == `DSP_OFS_TRIP) && avs_byteenable[3]
                 && avs_writedata[`DSP_TRIP_CLEAR_BIT];
  end

  // ========================================================================
  // Detection conditions
  always_comb begin
    // Torque mode blocks ride-through
    ride_allowed = ctrl.ride_en & ~meas.torque_mode;
    stall_cond = ctrl.stall_en & meas.torque_limit & meas.speed_very_low
                 & meas.accelerating;
    case (ctrl.ploss_mode)
      dsp_pkg::DSP_PL_TRIP: ploss_cond = meas.phase_missing;
      dsp_pkg::DSP_PL_START: ploss_cond = meas.phase_missing & meas.in_start;
      default: ploss_cond = 1'b0;
    endcase
    // Start mode sets the window only while starting
    if (meas.in_start && meas.start_mode == dsp_pkg::DSP_SM_DC) begin
      ploss_limit = PLOSS_DC_CYC;
    end else if (meas.in_start && meas.start_mode == dsp_pkg::DSP_SM_FAST) begin
      ploss_limit = PLOSS_FAST_CYC;
    end else begin
      ploss_limit = PLOSS_RUN_CYC;
    end
    stall_expired = stall_cond && (stall_cnt >= STALL_CYC - 1);
    ploss_expired = ploss_cond && (ploss_cnt >= ploss_limit - 1);
  end

  // ========================================================================
  // Detection timers, cleared whenever the condition drops out
  always_comb begin
    next_stall_cnt = 32'h0000_0000;
    next_ploss_cnt = 32'h0000_0000;
    if (stall_cond && state != dsp_pkg::DSP_TRIP) begin
      next_stall_cnt = stall_cnt + 32'h0000_0001;
    end
    if (ploss_cond && state != dsp_pkg::DSP_TRIP) begin
      next_ploss_cnt = ploss_cnt + 32'h0000_0001;
    end
  end

  // ========================================================================
  // Trip arbitration; overvoltage first because a falling load is worst
  always_comb begin
    new_trip = dsp_pkg::DSP_TC_NONE;
    if (meas.chopper_fault) begin
      new_trip = dsp_pkg::DSP_TC_OVERVOLT;
    end else if (ploss_expired) begin
      new_trip = dsp_pkg::DSP_TC_MOTOR_LOST;
    end else if (stall_expired) begin
      new_trip = dsp_pkg::DSP_TC_LOCKED_ROTOR;
    end else if (meas.ext_trip[0]) begin
      new_trip = dsp_pkg::DSP_TC_EXT1;
    end else if (meas.ext_trip[1]) begin
      new_trip = dsp_pkg::DSP_TC_EXT2;
    end else if (meas.ext_trip[2]) begin
      new_trip = dsp_pkg::DSP_TC_EXT3;
    end else if (meas.ext_trip[3]) begin
      new_trip = dsp_pkg::DSP_TC_EXT4;
    end
  end

  // ========================================================================
  // Supervisor state machine
  always_comb begin
    next_state = state;
    next_trip = trip;
    case (state)
      dsp_pkg::DSP_RUN: begin
        if (new_trip != dsp_pkg::DSP_TC_NONE) begin
          next_state = dsp_pkg::DSP_TRIP;
          next_trip = new_trip;
        end else if (ride_allowed && meas.mains_dip && !meas.standstill) begin
          next_state = dsp_pkg::DSP_RIDE;
        end
      end
      dsp_pkg::DSP_RIDE: begin
        if (new_trip != dsp_pkg::DSP_TC_NONE) begin
          next_state = dsp_pkg::DSP_TRIP;
          next_trip = new_trip;
        end else if (!ride_allowed || !meas.mains_dip || meas.standstill) begin
          next_state = dsp_pkg::DSP_RUN;
        end
      end
      dsp_pkg::DSP_TRIP: begin
        // Trip holds until software clears it
        if (trip_clear) begin
          next_state = dsp_pkg::DSP_RUN;
          next_trip = dsp_pkg::DSP_TC_NONE;
        end
      end
      default: begin
        next_state = dsp_pkg::DSP_RUN;
        next_trip = dsp_pkg::DSP_TC_NONE;
      end
    endcase
  end

  // ========================================================================
  // Blink divider, free running only during ride-through
  always_comb begin
    next_blink_cnt = 32'h0000_0000;
    next_blink = 1'b1;
    if (state == dsp_pkg::DSP_RIDE) begin
      next_blink = blink;
      next_blink_cnt = blink_cnt + 32'h0000_0001;
      if (blink_cnt >= BLINK_CYC - 1) begin
        next_blink_cnt = 32'h0000_0000;
        next_blink = ~blink;
      end
    end
  end

  // ========================================================================
  // Events, sticky status with write-one-clear; a set beats a clear
  always_comb begin
    events = '0;
    events.ride_start = (state == dsp_pkg::DSP_RUN) && (next_state == dsp_pkg::DSP_RIDE);
    if (state != dsp_pkg::DSP_TRIP && next_state == dsp_pkg::DSP_TRIP) begin
      events.overvolt = (next_trip == dsp_pkg::DSP_TC_OVERVOLT);
      events.motor_lost = (next_trip == dsp_pkg::DSP_TC_MOTOR_LOST);
      events.stall = (next_trip == dsp_pkg::DSP_TC_LOCKED_ROTOR);
      events.ext[0] = (next_trip == dsp_pkg::DSP_TC_EXT1);
      events.ext[1] = (next_trip == dsp_pkg::DSP_TC_EXT2);
      events.ext[2] = (next_trip == dsp_pkg::DSP_TC_EXT3);
      events.ext[3] = (next_trip == dsp_pkg::DSP_TC_EXT4);
    end
    next_status = status;
    next_mask = mask;
    next_ctrl = ctrl;
    if (wr_go && avs_byteenable[0]) begin
      if (avs_address == `DSP_OFS_STATUS) begin
        next_status = status & ~dsp_pkg::dsp_evt_t'(avs_writedata[7:0]);
      end
      if (avs_address == `DSP_OFS_MASK) begin
        next_mask = dsp_pkg::dsp_evt_t'(avs_writedata[7:0]);
      end
      if (avs_address == `DSP_OFS_CTRL) begin
        next_ctrl = dsp_pkg::dsp_ctrl_t'(avs_writedata[4:0]);
      end
    end
    next_status = next_status | events;
  end

  // ========================================================================
  // Trip text store: 4 texts of 16 characters, 4 characters per word
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      next_text[i] = text[i];
    end
    if (wr_go && avs_address[7:6] == 2'b01) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          next_text[{word_sel[3:0], b[1:0]}] = avs_writedata[b*8 +: 8];
        end
      end
    end
  end

  // ========================================================================
  // Read mux; unmapped addresses read as zero
  always_comb begin
    next_rdata = rdata;
    shown_idx = 4'h0;
    if (trip >= dsp_pkg::DSP_TC_EXT1) begin
      shown_idx = {trip[1:0] - 2'b00, 2'b00}; // External trip text base word
    end
    if (rd_go) begin
      next_rdata = 32'h0000_0000;
      if (avs_address == `DSP_OFS_CTRL) begin
        next_rdata[4:0] = ctrl;
      end else if (avs_address == `DSP_OFS_STATUS) begin
        next_rdata[7:0] = status;
      end else if (avs_address == `DSP_OFS_MASK) begin
        next_rdata[7:0] = mask;
      end else if (avs_address == `DSP_OFS_TRIP) begin
        next_rdata[3:0] = trip;
        next_rdata[`DSP_TRIP_ACTIVE_BIT] = (state == dsp_pkg::DSP_TRIP);
        next_rdata[`DSP_TRIP_RIDE_BIT] = (state == dsp_pkg::DSP_RIDE);
      end else if (avs_address[7:6] == 2'b01) begin
        next_rdata = {text[{word_sel[3:0], 2'd3}], text[{word_sel[3:0], 2'd2}],
                      text[{word_sel[3:0], 2'd1}], text[{word_sel[3:0], 2'd0}]};
      end else if (avs_address[7:4] == 4'h8 && trip >= dsp_pkg::DSP_TC_EXT1) begin
        // Text of the external trip that is latched now
        next_rdata = {text[{shown_idx + {2'b00, word_sel[1:0]}, 2'd3}],
                      text[{shown_idx + {2'b00, word_sel[1:0]}, 2'd2}],
                      text[{shown_idx + {2'b00, word_sel[1:0]}, 2'd1}],
                      text[{shown_idx + {2'b00, word_sel[1:0]}, 2'd0}]};
      end
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= dsp_pkg::DSP_RUN;
      trip <= dsp_pkg::DSP_TC_NONE;
      ctrl <= dsp_pkg::dsp_ctrl_t'(`DSP_CTRL_RESET);
      status <= '0;
      mask <= dsp_pkg::dsp_evt_t'(`DSP_MASK_RESET);
      stall_cnt <= 32'h0000_0000;
      ploss_cnt <= 32'h0000_0000;
      blink_cnt <= 32'h0000_0000;
      blink <= 1'b1;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      trip <= next_trip;
      ctrl <= next_ctrl;
      status <= next_status;
      mask <= next_mask;
      stall_cnt <= next_stall_cnt;
      ploss_cnt <= next_ploss_cnt;
      blink_cnt <= next_blink_cnt;
      blink <= next_blink;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Text store with "Ext Trip N" defaults, rest space filled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int t = 0; t < 4; t++) begin
        for (int c = 0; c < 16; c++) begin
          if (c < 9) begin
            text[t*16 + c] <= TEXT_STEM[(8 - c)*8 +: 8];
          end else if (c == 9) begin
            text[t*16 + c] <= ASCII_ONE + 8'(t);
          end else begin
            text[t*16 + c] <= ASCII_SPACE;
          end
        end
      end
    end else begin
      for (int i = 0; i < 64; i++) begin
        text[i] <= next_text[i];
      end
    end
  end

  // ========================================================================
  // Outputs to the drive
  always_comb begin
    avs_readdata = rdata;
    // Speed is pulled down only in the ride state, never with setting 0
    speed_ramp_down = (state == dsp_pkg::DSP_RIDE);
    decel_limit = ctrl.ovc_en & ~meas.torque_mode & meas.decelerating
                  & meas.dc_link_high & (state != dsp_pkg::DSP_TRIP);
    coast_stop = (state == dsp_pkg::DSP_TRIP);
    trip_code = trip;
    // Steady for trip or limit, blinking in ride
    if (state == dsp_pkg::DSP_RIDE) begin
      led_trip_limit = blink;
    end else begin
      led_trip_limit = (state == dsp_pkg::DSP_TRIP) | meas.torque_limit;
    end
    irq = |(status & mask);
  end

endmodule : dsp_supervisor
`default_nettype wire

/* File: dsp_supervisor_asserts.sv */
// Concurrent checks on the protection supervisor ports
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Port checker
module dsp_chk #(
  parameter int unsigned STALL_CYC = 40,
  parameter int unsigned PLOSS_FAST_CYC = 4
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic avs_waitrequest, // Bus stall
  input wire dsp_pkg::dsp_meas_t meas, // Drive state
  input wire logic speed_ramp_down, // Ride command
  input wire logic decel_limit, // Deceleration hold
  input wire logic coast_stop, // Coast command
  input wire logic [3:0] trip_code, // Trip code
  input wire logic led_trip_limit // Indicator
);
  int unsigned stall_run;
  int unsigned loss_run;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Unbroken run of the stall and phase-loss trip causes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stall_run <= 0;
      loss_run <= 0;
    end else begin
      stall_run <= (meas.torque_limit && meas.speed_very_low && meas.accelerating) ?
        stall_run + 1 : 0;
      loss_run <= meas.phase_missing ? loss_run + 1 : 0;
    end
  end
  // Steps of a bus request and of a ride
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ride_go; $rose(speed_ramp_down); endsequence
  property p_one_wait; s_req |=> !avs_waitrequest; endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus wait not one cycle");
  property p_ride_cause;
    speed_ramp_down |-> $past(meas.mains_dip) && !$past(meas.torque_mode) &&
      !$past(meas.standstill);
  endproperty
  a_ride_cause: assert property (p_ride_cause) else $error("ride without cause");
  property p_ride_stop;
    speed_ramp_down && (!meas.mains_dip || meas.standstill || meas.torque_mode)
      |=> !speed_ramp_down;
  endproperty
  a_ride_stop: assert property (p_ride_stop) else $error("ride did not end");
  property p_led_ride; s_ride_go |-> led_trip_limit; endproperty
  a_led_ride: assert property (p_led_ride) else $error("blink not started high");
  property p_led_rest; !speed_ramp_down |-> led_trip_limit == (coast_stop || meas.torque_limit);
  endproperty
  a_led_rest: assert property (p_led_rest) else $error("indicator wrong outside ride");
  property p_decel;
    decel_limit |-> meas.decelerating && meas.dc_link_high && !meas.torque_mode && !coast_stop;
  endproperty
  a_decel: assert property (p_decel) else $error("deceleration hold without cause");
  property p_trip_excl; coast_stop |-> !speed_ramp_down && trip_code != 4'h0; endproperty
  a_trip_excl: assert property (p_trip_excl) else $error("coast without trip code");
  property p_trip_hold; coast_stop && !avs_write |=> coast_stop; endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip dropped alone");
  property p_stall_time;
    $rose(coast_stop) && trip_code == dsp_pkg::DSP_TC_LOCKED_ROTOR |-> stall_run >= STALL_CYC;
  endproperty
  a_stall_time: assert property (p_stall_time) else $error("stall trip too early");
  property p_loss_time;
    $rose(coast_stop) && trip_code == dsp_pkg::DSP_TC_MOTOR_LOST |-> loss_run >= PLOSS_FAST_CYC;
  endproperty
  a_loss_time: assert property (p_loss_time) else $error("loss trip too early");
endmodule : dsp_chk

bind dsp_supervisor dsp_chk #(.STALL_CYC(STALL_CYC), .PLOSS_FAST_CYC(PLOSS_FAST_CYC)) dsp_chk_i (
  .clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .meas, .speed_ramp_down,
  .decel_limit, .coast_stop, .trip_code, .led_trip_limit);
`default_nettype wire

/* File: dsp_drive_model.sv */
// Drive model feeding measurements
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Drive model
module dsp_drive_model #(
  parameter int unsigned SPIN = 30
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire dsp_pkg::dsp_meas_t want, // Conditions set by the bench
  input wire logic speed_ramp_down, // Ride command
  input wire logic coast_stop, // Coast command
  output var dsp_pkg::dsp_meas_t meas // Measured state
);
  logic [7:0] speed;
  logic [7:0] next_speed;
  // Speed bleeds off while ramped or coasting
  always_comb begin
    next_speed = 8'(SPIN);
    if (speed_ramp_down || coast_stop) begin
      next_speed = (speed != 8'h00) ? speed - 8'h01 : 8'h00;
    end
  end
  // Speed register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed <= 8'(SPIN);
    end else begin
      speed <= next_speed;
    end
  end
  // A coasting motor cannot accelerate; a ramped one decelerates
  always_comb begin
    meas = want;
    meas.standstill = want.standstill || (speed == 8'h00);
    meas.accelerating = want.accelerating && !coast_stop;
    meas.decelerating = want.decelerating || speed_ramp_down;
  end
endmodule : dsp_drive_model
`default_nettype wire

/* File: drive_protection_supervisor_tb.sv */
// Self-checking bench of the protection supervisor
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Bench top
module drive_protection_supervisor_tb;
  localparam int unsigned SC = 40;
  localparam logic [7:0] PL_CTRL [6] = '{8'h15, 8'h15, 8'h15, 8'h19, 8'h19, 8'h11};
  localparam int PL_LIM [6] = '{20, 8, 4, 99, 8, 99};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  dsp_pkg::dsp_meas_t want = '0;
  dsp_pkg::dsp_meas_t meas;
  logic speed_ramp_down, decel_limit, coast_stop, led_trip_limit, irq, led_prev;
  logic [3:0] trip_code;
  logic [31:0] exp_q[$];
  logic [31:0] rnd;
  integer seed = 32'h776a4302;
  int n_fail = 0;
  int check_count = 0;
  int i, k;

  // Clock, 8 ns period
  always #4 clk = ~clk;

  dsp_supervisor #(.STALL_CYC(SC), .PLOSS_RUN_CYC(20), .PLOSS_DC_CYC(8), .PLOSS_FAST_CYC(4),
    .BLINK_CYC(3)) dsp_supervisor_i (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .meas,
    .speed_ramp_down, .decel_limit, .coast_stop, .trip_code, .led_trip_limit, .irq);
  dsp_drive_model #(.SPIN(30)) dsp_drive_model_i (.clk, .rst, .want, .speed_ramp_down,
    .coast_stop, .meas);

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic clr();
    bus(1'b1, 8'h0c, 32'h80000000);
  endtask : clr

  // Cycles until coast shows, 99 if none in 60
  task automatic time_trip(output int n);
    n = 99;
    for (int c = 0; c < 60; c++) begin
      @(negedge clk);
      if (coast_stop === 1'b1 && n == 99) n = c;
    end
  endtask : time_trip

  // Oldest note taken at each answering edge
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, exp_q.pop_front());
  end

  // Watchdog, well past the run
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h11);
    for (i = 0; i < 4; i++) begin
      rd(8'h40 + 8'(16 * i), 32'h20747845);
      rd(8'h44 + 8'(16 * i), 32'h70697254);
      rd(8'h48 + 8'(16 * i), 32'h20203120 + 32'(i << 8));
      rd(8'h4c + 8'(16 * i), 32'h20202020);
    end
    rnd = $random(seed);
    bus(1'b1, 8'h54, rnd);
    rd(8'h54, rnd);
    bus(1'b1, 8'h20, rnd);
    rd(8'h20, 32'h0);
    rnd = $random(seed);
    bus(1'b1, 8'h08, {24'h0, rnd[7:0] | 8'h01});
    // Ride through a dip until standstill
    @(posedge clk);
    want.mains_dip <= 1'b1;
    repeat (2) @(negedge clk);
    chk(speed_ramp_down, 1'b1);
    k = 0;
    led_prev = led_trip_limit;
    for (i = 0; i < 12; i++) begin
      @(negedge clk);
      if (led_trip_limit !== led_prev) k++;
      led_prev = led_trip_limit;
    end
    chk(k >= 3, 1'b1);
    while (meas.standstill !== 1'b1) @(negedge clk);
    @(negedge clk);
    chk(speed_ramp_down, 1'b0);
    @(posedge clk);
    want.mains_dip <= 1'b0;
    repeat (3) @(negedge clk);
    chk(speed_ramp_down, 1'b0);
    rd(8'h04, 32'h01);
    chk(irq, 1'b1);
    bus(1'b1, 8'h08, 32'h0);
    @(negedge clk);
    chk(irq, 1'b0);
    bus(1'b1, 8'h08, 32'hff);
    bus(1'b1, 8'h04, 32'h01);
    @(negedge clk);
    chk(irq, 1'b0);
    // Ride off, torque mode, decel hold
    bus(1'b1, 8'h00, 32'h10);
    @(posedge clk);
    want.mains_dip <= 1'b1;
    want.torque_mode <= 1'b1;
    want.decelerating <= 1'b1;
    want.dc_link_high <= 1'b1;
    repeat (4) @(negedge clk);
    chk(speed_ramp_down, 1'b0);
    bus(1'b1, 8'h00, 32'h11);
    repeat (3) @(negedge clk);
    chk(speed_ramp_down, 1'b0);
    chk(decel_limit, 1'b0);
    @(posedge clk);
    want.torque_mode <= 1'b0;
    want.mains_dip <= 1'b0;
    @(negedge clk);
    chk(decel_limit, 1'b1);
    bus(1'b1, 8'h00, 32'h01);
    @(negedge clk);
    chk(decel_limit, 1'b0);
    @(posedge clk);
    want.decelerating <= 1'b0;
    want.dc_link_high <= 1'b0;
    // Stall with one gap just before expiry
    bus(1'b1, 8'h00, 32'h13);
    want.torque_limit <= 1'b1;
    want.speed_very_low <= 1'b1;
    want.accelerating <= 1'b1;
    repeat (SC - 1) @(posedge clk);
    want.accelerating <= 1'b0;
    @(posedge clk);
    want.accelerating <= 1'b1;
    time_trip(k);
    chk(k, SC);
    chk(trip_code, 4'h3);
    rd(8'h0c, 32'h13);
    rd(8'h04, 32'h02);
    clr();
    bus(1'b1, 8'h04, 32'hff);
    bus(1'b1, 8'h00, 32'h11);
    time_trip(k);
    chk(k, 99);
    want.torque_limit <= 1'b0;
    want.accelerating <= 1'b0;
    // Phase loss per setting and start mode
    for (i = 0; i < 6; i++) begin
      bus(1'b1, 8'h00, {24'h0, PL_CTRL[i]});
      want.in_start <= (i % 3 != 0);
      want.start_mode <= dsp_pkg::dsp_start_t'(i % 3);
      want.phase_missing <= 1'b1;
      time_trip(k);
      chk(k, PL_LIM[i]);
      if (k != 99) chk(trip_code, 4'h2);
      @(posedge clk);
      want.phase_missing <= 1'b0;
      clr();
    end
    // Chopper fault, control off with chopper
    bus(1'b1, 8'h00, 32'h01);
    want.chopper_fault <= 1'b1;
    time_trip(k);
    chk(trip_code, 4'h1);
    @(posedge clk);
    want.chopper_fault <= 1'b0;
    clr();
    // External trips show their texts
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      want.ext_trip <= 4'h1 << i;
      time_trip(k);
      chk(trip_code, 4'(4 + i));
      rd(8'h80, 32'h20747845);
      rd(8'h88, 32'h20203120 + 32'(i << 8));
      @(posedge clk);
      want.ext_trip <= 4'h0;
      clr();
    end
    rd(8'h80, 32'h0);
    summarize();
  end
endmodule : drive_protection_supervisor_tb
`default_nettype wire
